// *** include/aic_pkg.sv ***
// Shared constants for the converter two-wire port and its bus master
package aic_pkg;
   // Clock
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned CLK_PERIOD_NS = 20;

   // Slave addressing
   localparam logic [6:0] SLAVE_BASE  = 7'h48;
   localparam logic [7:0] GCALL_ADDR  = 8'h00;
   localparam logic [7:0] GCALL_RESET = 8'h06;
   localparam logic [4:0] HS_CODE     = 5'h01;

   // Register pointer values
   localparam logic [1:0] PTR_RESULT = 2'h0;
   localparam logic [1:0] PTR_CONFIG = 2'h1;
   localparam logic [1:0] PTR_LO     = 2'h2;
   localparam logic [1:0] PTR_HI     = 2'h3;

   // Values after reset
   localparam logic [15:0] RESULT_RST = 16'h0000;
   localparam logic [15:0] CFG_RST    = 16'h8583;
   localparam logic [15:0] LO_RST     = 16'h8000;
   localparam logic [15:0] HI_RST     = 16'h7FFF;

   // Configuration fields
   localparam int unsigned CFG_START_BIT = 15;
   localparam int unsigned CFG_MODE_BIT  = 8;

   // Times and cycle counts
   localparam int unsigned WAKE_US     = 25;
   localparam int unsigned WAKE_CYC    = (WAKE_US * 1000 + CLK_PERIOD_NS - 1)
                                         / CLK_PERIOD_NS;
   localparam int unsigned TIMEOUT_MS  = 25;
   localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int unsigned SCL_PERIOD_NS = 10_000;
   localparam int unsigned QTR_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

   // Master register map
   localparam logic [7:0] HREG_CMD  = 8'h00;
   localparam logic [7:0] HREG_STAT = 8'h04;
   localparam int unsigned CMD_ACK_BIT   = 8;
   localparam int unsigned CMD_START_BIT = 9;
   localparam int unsigned CMD_XFER_BIT  = 10;
   localparam int unsigned CMD_STOP_BIT  = 11;
   localparam int unsigned STAT_BUSY_BIT = 0;
   localparam int unsigned STAT_NACK_BIT = 1;
   localparam int unsigned STAT_RX_LSB   = 8;
endpackage : aic_pkg

// *** include/aic_if.sv ***
// Open-drain two-wire bus joining master and converter slave
`timescale 1ns/1ps
interface aic_if;
   logic scl_o_m;
   logic scl_oe_m;
   logic sda_o_m;
   logic sda_oe_m;
   logic sda_o_d;
   logic sda_oe_d;
   logic scl;
   logic sda;

   // Wired-AND with pull-ups
   assign scl = ~(scl_oe_m & ~scl_o_m);
   assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_d & ~sda_o_d));

   modport dev (input scl, input sda, output sda_o_d, output sda_oe_d);
   modport host (input scl, input sda, output scl_o_m, output scl_oe_m,
                 output sda_o_m, output sda_oe_m);
endinterface : aic_if

// *** verilog/aic_sync.sv ***
// Two-flop synchroniser for asynchronous inputs
`timescale 1ns/1ps
module aic_sync #(
   parameter int unsigned W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         mclk,
   input  wire logic         rst_b,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= RST_VAL;
         q    <= RST_VAL;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule : aic_sync

// *** verilog/aic_slave.sv ***
// Converter slave port: two-wire protocol, registers and conversion control
// Functional notes
// - Reset loads defaults, then powers down
// - General call reset byte resets device
// - Single-shot waits powered down for start bit
// - Start wakes 25us, clears bit, converts once
// - Start write during conversion is ignored
// - Continuous mode stores result, restarts immediately
// - New config applies from next conversion
// - Mode bit or reset returns single-shot
// - Slave only; data line driven low only
// - Bus stalled mid-transfer over 25ms times out
// - Address pin picks one of four addresses
// - Acknowledge own address and data bytes
// - Hs code not acknowledged, enters Hs mode
// - Stop returns to normal speed
// - Write is pointer then MSB, LSB
// - Read sends MSB then LSB
// - Master nack, start or stop ends sending
// - Repeated start begins new transfer
// - Pointer selects result, config, low, high
// - Pointer kept until next write
// - Config resets to 8583h
`timescale 1ns/1ps
module aic_slave
   import aic_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Two-wire bus
   aic_if.dev               bus,
   // Address pin connection: 0 gnd, 1 supply, 2 data, 3 clock
   input  wire logic [1:0]  addr_sel,
   // Converter core
   output logic             conv_power,
   output logic             conv_start,
   output logic [15:0]      conv_cfg,
   input  wire logic        conv_done,
   input  wire logic [15:0] conv_data,
   // Bus status
   output logic             hs_mode,
   output logic             bus_timeout
);
   if (TIMEOUT_CYCLES < 2) begin : g_chk
      $error("TIMEOUT_CYCLES too small");
   end

   typedef enum logic [2:0] {
      B_IDLE = 3'b000, B_ADDR = 3'b001, B_RX = 3'b011,
      B_TX   = 3'b010, B_SKIP = 3'b110
   } aic_bus_t;
   typedef enum logic [1:0] {
      C_DOWN = 2'b00, C_WAKE = 2'b01, C_CONV = 2'b11
   } aic_conv_t;

   localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
   localparam int unsigned WW = $clog2(WAKE_CYC + 1);

   logic [3:0]  s_in;
   logic        scl_s, sda_s, scl_q, sda_q;
   logic        scl_rise, scl_fall, start_c, stop_c;
   logic [6:0]  my_addr;
   aic_bus_t    bst;
   aic_conv_t   cst;
   logic [3:0]  bitcnt;
   logic        ack_slot, sda_pull, gcall;
   logic [1:0]  byte_idx;
   logic [7:0]  shreg, msb, txb;
   logic [15:0] rd_word, rd_hold, wdata;
   logic        ptr_we, reg_we, gc_rst;
   logic [1:0]  ptr;
   logic [14:0] cfg;
   logic [15:0] lo_th, hi_th, result;
   logic        os_idle, os_wr, mode;
   logic [TW-1:0] idle_cnt;
   logic [WW-1:0] wcnt;

   aic_sync #(.W(4), .RST_VAL(4'hF)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     ({addr_sel, bus.scl, bus.sda}),
      .q     (s_in)
   );

   assign scl_s = s_in[1];
   assign sda_s = s_in[0];
   assign my_addr = SLAVE_BASE | {5'h00, s_in[3:2]};

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl_s;
         sda_q <= sda_s;
      end
   end

   assign scl_rise = scl_s & ~scl_q;
   assign scl_fall = ~scl_s & scl_q;
   assign start_c  = scl_s & scl_q & sda_q & ~sda_s;
   assign stop_c   = scl_s & scl_q & ~sda_q & sda_s;

   assign bus.sda_o_d  = 1'b0;
   assign bus.sda_oe_d = sda_pull;

   // bytes past the register read as ones
   always_comb begin
      case (byte_idx)
         2'h1:    txb = rd_hold[15:8];
         2'h2:    txb = rd_hold[7:0];
         default: txb = 8'hFF;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         idle_cnt    <= '0;
         bus_timeout <= 1'b0;
      end else begin
         bus_timeout <= 1'b0;
         if (bst == B_IDLE || scl_rise || scl_fall || start_c || stop_c) begin
            idle_cnt <= '0;
         end else if (idle_cnt == TW'(TIMEOUT_CYCLES)) begin
            idle_cnt    <= '0;
            bus_timeout <= 1'b1;
         end else begin
            idle_cnt <= idle_cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         bst      <= B_IDLE;
         bitcnt   <= 4'h0;
         ack_slot <= 1'b0;
         sda_pull <= 1'b0;
         gcall    <= 1'b0;
         byte_idx <= 2'h0;
         shreg    <= 8'h00;
         msb      <= 8'h00;
         rd_hold  <= 16'h0000;
         hs_mode  <= 1'b0;
         ptr_we   <= 1'b0;
         reg_we   <= 1'b0;
         gc_rst   <= 1'b0;
      end else begin
         ptr_we <= 1'b0;
         reg_we <= 1'b0;
         gc_rst <= 1'b0;
         if (start_c) begin
            bst      <= B_ADDR;
            bitcnt   <= 4'h0;
            ack_slot <= 1'b0;
            sda_pull <= 1'b0;
         end else if (stop_c || bus_timeout) begin
            bst      <= B_IDLE;
            ack_slot <= 1'b0;
            sda_pull <= 1'b0;
            if (stop_c) begin
               hs_mode <= 1'b0;
            end
         end else if (bst != B_IDLE && bst != B_SKIP) begin
            if (scl_rise) begin
               if (!ack_slot && bitcnt < 4'h8) begin
                  shreg  <= {shreg[6:0], sda_s};
                  bitcnt <= bitcnt + 1'b1;
               end else if (ack_slot && bst == B_TX && sda_s) begin
                  bst <= B_SKIP;
               end
            end else if (scl_fall) begin
               if (!ack_slot && bitcnt == 4'h8) begin
                  ack_slot <= 1'b1;
                  sda_pull <= 1'b0;
                  case (bst)
                     B_ADDR: begin
                        if (shreg[7:3] == HS_CODE) begin
                           hs_mode <= 1'b1;
                           bst     <= B_SKIP;
                        end else if (shreg[7:1] == my_addr) begin
                           sda_pull <= 1'b1;
                           gcall    <= 1'b0;
                           byte_idx <= shreg[0] ? 2'h1 : 2'h0;
                           rd_hold  <= rd_word;
                           bst      <= shreg[0] ? B_TX : B_RX;
                        end else if (shreg == GCALL_ADDR) begin
                           sda_pull <= 1'b1;
                           gcall    <= 1'b1;
                           byte_idx <= 2'h0;
                           bst      <= B_RX;
                        end else begin
                           bst <= B_SKIP;
                        end
                     end
                     B_RX: begin
                        sda_pull <= 1'b1;
                        byte_idx <= byte_idx + {1'b0, byte_idx != 2'h3};
                        if (gcall) begin
                           gc_rst <= byte_idx == 2'h0 && shreg == GCALL_RESET;
                        end else begin
                           ptr_we <= byte_idx == 2'h0;
                           reg_we <= byte_idx == 2'h2;
                           if (byte_idx == 2'h1) begin
                              msb <= shreg;
                           end
                        end
                     end
                     default: begin
                        byte_idx <= byte_idx + {1'b0, byte_idx != 2'h3};
                     end
                  endcase
               end else if (ack_slot) begin
                  ack_slot <= 1'b0;
                  bitcnt   <= 4'h0;
                  sda_pull <= bst == B_TX && !txb[7];
               end else if (bst == B_TX) begin
                  sda_pull <= !txb[3'(4'h7 - bitcnt)];
               end
            end
         end
      end
   end

   assign wdata = {msb, shreg};
   assign mode  = cfg[CFG_MODE_BIT];
   assign os_wr = reg_we && ptr == PTR_CONFIG && wdata[CFG_START_BIT];

   always_comb begin
      case (ptr)
         PTR_RESULT: rd_word = result;
         PTR_CONFIG: rd_word = {os_idle, cfg};
         PTR_LO:     rd_word = lo_th;
         default:    rd_word = hi_th;
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ptr    <= PTR_RESULT;
         cfg    <= CFG_RST[14:0];
         lo_th  <= LO_RST;
         hi_th  <= HI_RST;
         result <= RESULT_RST;
      end else if (gc_rst) begin
         ptr    <= PTR_RESULT;
         cfg    <= CFG_RST[14:0];
         lo_th  <= LO_RST;
         hi_th  <= HI_RST;
         result <= RESULT_RST;
      end else begin
         if (ptr_we) begin
            ptr <= shreg[1:0];
         end
         if (reg_we) begin
            case (ptr)
               PTR_CONFIG: cfg   <= wdata[14:0];
               PTR_LO:     lo_th <= wdata;
               PTR_HI:     hi_th <= wdata;
               default:    ;
            endcase
         end
         if (cst == C_CONV && conv_done) begin
            result <= conv_data;
         end
      end
   end

   assign conv_power = cst != C_DOWN;

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cst        <= C_DOWN;
         wcnt       <= '0;
         os_idle    <= CFG_RST[CFG_START_BIT];
         conv_start <= 1'b0;
         conv_cfg   <= CFG_RST;
      end else if (gc_rst) begin
         cst        <= C_DOWN;
         wcnt       <= '0;
         os_idle    <= CFG_RST[CFG_START_BIT];
         conv_start <= 1'b0;
         conv_cfg   <= CFG_RST;
      end else begin
         conv_start <= 1'b0;
         case (cst)
            C_DOWN: begin
               // wait for start bit or continuous
               if (os_wr || !mode) begin
                  cst     <= C_WAKE;
                  wcnt    <= '0;
                  os_idle <= 1'b0;
               end
            end
            C_WAKE: begin
               if (wcnt == WW'(WAKE_CYC - 1)) begin
                  cst        <= C_CONV;
                  conv_start <= 1'b1;
                  conv_cfg   <= {1'b0, cfg};
               end else begin
                  wcnt <= wcnt + 1'b1;
               end
            end
            C_CONV: begin
               if (conv_done) begin
                  if (!mode) begin
                     conv_start <= 1'b1;
                     conv_cfg   <= {1'b0, cfg};
                  end else begin
                     cst     <= C_DOWN;
                     os_idle <= 1'b1;
                  end
               end
            end
            default: cst <= C_DOWN;
         endcase
      end
   end
endmodule : aic_slave

// *** verilog/aic_master.sv ***
// Byte-level two-wire bus master commanded over Wishbone
`timescale 1ns/1ps
module aic_master
   import aic_pkg::*;
#(
   parameter int unsigned QTR = QTR_CYC
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // Wishbone slave
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // Two-wire bus
   aic_if.host              bus
);
   if (QTR < 4) begin : g_chk
      $error("QTR too small");
   end

   typedef enum logic [1:0] {
      H_IDLE = 2'b00, H_STA = 2'b01, H_BIT = 2'b11, H_STO = 2'b10
   } aic_hst_t;

   localparam int unsigned DW = $clog2(QTR + 1);

   aic_hst_t    hst;
   logic [1:0]  s_in;
   logic [DW-1:0] div;
   logic        tick, busy, cmd_wr;
   logic [1:0]  ph;
   logic [3:0]  bitn;
   logic [8:0]  shift, rx;
   logic        p_xfer, p_stop;
   logic        scl_pull, sda_pull;

   aic_sync #(.W(2), .RST_VAL(2'h3)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     ({bus.scl, bus.sda}),
      .q     (s_in)
   );

   assign bus.scl_o_m  = 1'b0;
   assign bus.sda_o_m  = 1'b0;
   assign bus.scl_oe_m = scl_pull;
   assign bus.sda_oe_m = sda_pull;

   assign busy   = hst != H_IDLE;
   assign cmd_wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i
                   && wb_adr_i == HREG_CMD && (&wb_sel_i[1:0]);

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i == HREG_STAT) begin
               wb_dat_o[STAT_BUSY_BIT] <= busy;
               wb_dat_o[STAT_NACK_BIT] <= rx[0];
               wb_dat_o[STAT_RX_LSB +: 8] <= rx[8:1];
            end
         end
      end
   end

   // Quarter-period enable, held while the clock line is stretched
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         div  <= '0;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (!busy || (ph == 2'h2 && !s_in[1])) begin
            div <= '0;
         end else if (div == DW'(QTR - 1)) begin
            div  <= '0;
            tick <= 1'b1;
         end else begin
            div <= div + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         hst      <= H_IDLE;
         ph       <= 2'h0;
         bitn     <= 4'h0;
         shift    <= 9'h1FF;
         rx       <= 9'h000;
         p_xfer   <= 1'b0;
         p_stop   <= 1'b0;
         scl_pull <= 1'b0;
         sda_pull <= 1'b0;
      end else if (hst == H_IDLE) begin
         ph   <= 2'h0;
         bitn <= 4'h0;
         if (cmd_wr) begin
            shift  <= {wb_dat_i[7:0], wb_dat_i[CMD_ACK_BIT]};
            p_xfer <= wb_dat_i[CMD_XFER_BIT];
            p_stop <= wb_dat_i[CMD_STOP_BIT];
            if (wb_dat_i[CMD_START_BIT]) begin
               hst <= H_STA;
            end else if (wb_dat_i[CMD_XFER_BIT]) begin
               hst <= H_BIT;
            end else if (wb_dat_i[CMD_STOP_BIT]) begin
               hst <= H_STO;
            end
         end
      end else if (tick) begin
         ph <= ph + 1'b1;
         case (hst)
            H_STA: begin
               // start, repeated when the bus is held
               case (ph)
                  2'h0:    sda_pull <= 1'b0;
                  2'h1:    scl_pull <= 1'b0;
                  2'h2:    sda_pull <= 1'b1;
                  default: begin
                     scl_pull <= 1'b1;
                     hst <= p_xfer ? H_BIT : (p_stop ? H_STO : H_IDLE);
                  end
               endcase
            end
            H_BIT: begin
               // eight data bits then acknowledge slot
               case (ph)
                  2'h0:    sda_pull <= !shift[8];
                  2'h1:    scl_pull <= 1'b0;
                  2'h2:    rx <= {rx[7:0], s_in[0]};
                  default: begin
                     scl_pull <= 1'b1;
                     shift    <= {shift[7:0], 1'b1};
                     bitn     <= bitn + 1'b1;
                     if (bitn == 4'h8) begin
                        bitn <= 4'h0;
                        hst  <= p_stop ? H_STO : H_IDLE;
                     end
                  end
               endcase
            end
            default: begin
               case (ph)
                  2'h0:    sda_pull <= 1'b1;
                  2'h1:    scl_pull <= 1'b0;
                  2'h2:    sda_pull <= 1'b0;
                  default: hst <= H_IDLE;
               endcase
            end
         endcase
      end
   end
endmodule : aic_master

// *** verif/aic_asserts.sv ***
// Bus and conversion checks beside the two-wire link
`timescale 1ns/1ps
module aic_asserts
   import aic_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_b,
   // Bus lines
   input wire logic scl,
   input wire logic sda,
   input wire logic sda_o_d,
   input wire logic sda_oe_d,
   // Slave outputs
   input wire logic hs_mode,
   input wire logic conv_start,
   input wire logic conv_power
);
   logic [11:0] wake;
   logic        seen;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // Cycles since power-up, for the wake delay
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wake <= '0;
         seen <= 1'b0;
      end else if (!conv_power) begin
         wake <= '0;
         seen <= 1'b0;
      end else begin
         wake <= wake + 12'h001;
         seen <= seen | conv_start;
      end
   end
   a_dev_low_only: assert property (sda_oe_d |-> !sda_o_d)
      else $error("slave drives data high");
   a_ack_pulls_low: assert property (sda_oe_d |-> !sda)
      else $error("slave pull not seen on data");
   a_hold_scl_high: assert property (
      scl && $past(scl) |-> $stable(sda_oe_d))
      else $error("slave data changed with clock high");
   a_drive_scl_low: assert property (
      $rose(sda_oe_d) |-> !$past(scl) && !$past(scl, 2))
      else $error("slave drove data too soon after clock fall");
   a_release_low: assert property ($fell(sda_oe_d) |-> !scl)
      else $error("slave released data with clock high");
   a_hs_no_ack: assert property (
      $rose(hs_mode) |-> !sda_oe_d [*8] ##1 !sda_oe_d [*8]
      ##1 !sda_oe_d [*8] ##1 !sda_oe_d [*8])
      else $error("master code was acknowledged");
   a_hs_exit_stop: assert property (
      hs_mode && scl && $rose(sda) |-> ##[1:6] !hs_mode)
      else $error("high speed kept after stop");
   a_start_pulse: assert property (conv_start |=> !conv_start)
      else $error("conversion start repeated");
   a_start_powered: assert property (conv_start |-> conv_power)
      else $error("conversion started while powered down");
   a_wake_time: assert property (
      conv_start && !seen |-> wake >= WAKE_CYC - 2 && wake <= WAKE_CYC + 2)
      else $error("wake delay wrong");
   c_restart: cover property (conv_start && seen);
   c_hs: cover property ($rose(hs_mode));
   c_release: cover property ($fell(sda_oe_d));
endmodule : aic_asserts

// *** verif/testbench.sv ***
// Master and converter slave joined on one bus, run over Wishbone
`timescale 1ns/1ps
module testbench
   import aic_pkg::*;
;
   logic        mclk = 1'b0;
   logic        rst_b = 1'b0;
   logic        cyc, we, done, chk;
   logic [1:0]  asel;
   logic [6:0]  me;
   logic [7:0]  adr;
   logic [15:0] v, c, cdata, conv_cfg;
   logic [31:0] dat, q, wb_dat_o;
   logic        wb_ack_o, conv_power, conv_start, hs_mode, bus_timeout;
   logic [8:0]  eq[$];
   logic [15:0] cq[$];
   int          bad_count = 0, compares = 0, ticks = 0, starts = 0, tos = 0;
   always #(CLK_PERIOD_NS / 2) mclk = ~mclk;
   aic_if bus_if ();
   aic_slave #(.TIMEOUT_CYCLES(2000)) i_aic_slave (
      .mclk(mclk), .rst_b(rst_b), .bus(bus_if.dev), .addr_sel(asel),
      .conv_power(conv_power), .conv_start(conv_start), .conv_cfg(conv_cfg),
      .conv_done(done), .conv_data(cdata), .hs_mode(hs_mode),
      .bus_timeout(bus_timeout));
   aic_master #(.QTR(8)) i_aic_master (
      .mclk(mclk), .rst_b(rst_b), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bus(bus_if.host));
   aic_asserts i_aic_asserts (
      .mclk(mclk), .rst_b(rst_b), .scl(bus_if.scl), .sda(bus_if.sda),
      .sda_o_d(bus_if.sda_o_d), .sda_oe_d(bus_if.sda_oe_d),
      .hs_mode(hs_mode), .conv_start(conv_start), .conv_power(conv_power));
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic stop_test();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : stop_test
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      adr <= a;
      we <= w;
      dat <= d;
      cyc <= 1'b1;
      do @(posedge mclk); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      @(posedge mclk);
   endtask : wb
   // One byte: start, stop, byte, ack bit; expects byte and ack level
   task automatic op(input logic s, p, input logic [7:0] b, input logic k,
                     input logic [8:0] e);
      wb(HREG_CMD, 1'b1, {20'h0, p, 1'b1, s, k, b});
      do wb(HREG_STAT, 1'b0, '0); while (q[STAT_BUSY_BIT] !== 1'b0);
      eq.push_back(e);
      chk <= 1'b1;
      wb(HREG_STAT, 1'b0, '0);
      chk <= 1'b0;
   endtask : op
   task automatic w(input logic s, p, input logic [7:0] b, input logic n);
      op(s, p, b, 1'b1, {b, n});
   endtask : w
   task automatic ptr(input logic [1:0] p, input logic s);
      w(1'b1, 1'b0, {me, 1'b0}, 1'b0);
      w(1'b0, s, {6'h00, p}, 1'b0);
   endtask : ptr
   task automatic wreg(input logic [1:0] p, input logic [15:0] x);
      ptr(p, 1'b0);
      w(1'b0, 1'b0, x[15:8], 1'b0);
      w(1'b0, 1'b1, x[7:0], 1'b0);
   endtask : wreg
   // Read a word; e acks the LSB and reads one extra byte, nacked
   task automatic rd(input logic [15:0] x, input logic e);
      op(1'b1, 1'b0, {me, 1'b1}, 1'b1, {me, 2'b10});
      op(1'b0, 1'b0, 8'hFF, 1'b0, {x[15:8], 1'b0});
      op(1'b0, !e, 8'hFF, !e, {x[7:0], !e});
      if (e) op(1'b0, 1'b1, 8'hFF, 1'b1, 9'h1FF);
   endtask : rd
   task automatic dn(input logic [15:0] x);
      cdata <= x;
      done <= 1'b1;
      @(posedge mclk);
      done <= 1'b0;
   endtask : dn
   always @(posedge mclk) begin
      ticks++;
      if (bus_timeout === 1'b1) tos++;
      if (chk && wb_ack_o === 1'b1)
         check({wb_dat_o[15:8], wb_dat_o[1]}, eq.pop_front());
      if (conv_start === 1'b1) begin
         starts++;
         check(conv_cfg, cq.size() > 0 ? cq.pop_front() : 16'hDEAD);
      end
      if (ticks > 60000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      int n, s;
      {cyc, we, done, chk, asel, adr, dat, cdata} = '0;
      n = $urandom(32'h0E72);
      repeat (4) @(posedge mclk);
      rst_b <= 1'b1;
      repeat (4) @(posedge mclk);
      wb(8'h08, 1'b0, '0);
      check(q[15:0], 16'h0000);
      check({15'h0000, conv_power}, 16'h0000);
      for (s = 0; s < 4; s++) begin
         asel <= 2'(s);
         me = SLAVE_BASE + 7'(s);
         repeat (4) @(posedge mclk);
         w(1'b1, 1'b1, {me, 1'b0}, 1'b0);
         w(1'b1, 1'b1, {me ^ 7'h01, 1'b0}, 1'b1);
      end
      $display("test addresses done");
      s = $urandom_range(3);
      asel <= 2'(s);
      me = SLAVE_BASE + 7'(s);
      v = 16'($urandom);
      repeat (4) @(posedge mclk);
      wreg(PTR_LO, v);
      ptr(PTR_LO, 1'b0);
      rd(v, 1'b1);
      rd(v, 1'b0);
      ptr(PTR_CONFIG, 1'b1);
      rd(CFG_RST, 1'b0);
      $display("test registers done");
      v = {1'b1, 6'($urandom), 1'b1, 8'($urandom)};
      cq.push_back({1'b0, v[14:0]});
      wreg(PTR_CONFIG, v);
      rd({1'b0, v[14:0]}, 1'b0);
      wreg(PTR_CONFIG, v);
      c = 16'($urandom);
      dn(c);
      repeat (4) @(posedge mclk);
      check(conv_power, 1'b0);
      ptr(PTR_RESULT, 1'b1);
      rd(c, 1'b0);
      check(16'(starts), 16'h0001);
      $display("test single shot done");
      v = {1'b0, 6'($urandom), 1'b0, 8'($urandom)};
      cq.push_back(v);
      cq.push_back(v);
      n = starts;
      wreg(PTR_CONFIG, v);
      while (starts == n) @(posedge mclk);
      n = starts;
      dn(16'($urandom));
      repeat (2) @(posedge mclk);
      check(16'(starts - n), 16'h0001);
      v[14:9] = 6'($urandom);
      cq.push_back(v);
      wreg(PTR_CONFIG, v);
      n = starts;
      dn(16'($urandom));
      repeat (2) @(posedge mclk);
      check(16'(starts - n), 16'h0001);
      wreg(PTR_CONFIG, v | 16'h0100);
      dn(c);
      repeat (20) @(posedge mclk);
      check({15'h0000, conv_power}, 16'h0000);
      check(16'(starts - n), 16'h0001);
      $display("test continuous done");
      w(1'b1, 1'b0, GCALL_ADDR, 1'b0);
      w(1'b0, 1'b1, GCALL_RESET, 1'b0);
      rd(RESULT_RST, 1'b0);
      ptr(PTR_CONFIG, 1'b1);
      rd(CFG_RST, 1'b0);
      w(1'b1, 1'b0, {HS_CODE, 3'($urandom)}, 1'b1);
      check(hs_mode, 1'b1);
      w(1'b1, 1'b1, {me, 1'b0}, 1'b0);
      repeat (8) @(posedge mclk);
      check(hs_mode, 1'b0);
      $display("test reset and speed done");
      n = tos;
      w(1'b1, 1'b0, {me, 1'b0}, 1'b0);
      repeat (2200) @(posedge mclk);
      check(16'(tos - n), 16'h0001);
      w(1'b1, 1'b1, {me, 1'b0}, 1'b0);
      $display("test timeout done");
      stop_test();
   end
endmodule : testbench
